// ### bench/cmpctl_core_model.sv
// Behavioural analog comparator core and timer clock source
`timescale 1ns/1ps
`default_nettype none
module cmpctl_core_model (
  input  wire logic       clk_i,
  input  wire logic       en_i,
  input  wire logic [7:0] plus_i,
  input  wire logic [7:0] minus_i,
  input  wire logic       tmr_run_i,
  output logic            raw_o,
  output logic            tmr_o
);
  logic [1:0] div_q;
  initial begin
    raw_o = 1'b0;
    tmr_o = 1'b1;
    div_q = 2'h0;
  end
  // Powered-down core gives no decision, so it reads low
  always @(posedge clk_i) begin
    raw_o <= en_i && (plus_i > minus_i);
  end
  // Timer clock stands high when idle, so no stray falling edge
  always @(posedge clk_i) begin
    div_q <= div_q + 2'h1;
    if (!tmr_run_i) begin
      tmr_o <= 1'b1;
    end else if (div_q == 2'h3) begin
      tmr_o <= !tmr_o;
    end
  end
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdat;
  logic        pready, pslverr, raw, tclk, err;
  logic        other = 1'b0;
  logic        run = 1'b0;
  logic        cen, dben, pdac, mref, pref, mgnd, pgnd, cout, irq;
  logic [2:0]  msel, pselo;
  logic [3:0]  mpin;
  logic [1:0]  ppin;
  logic [7:0]  vp = 8'h40;
  logic [7:0]  vm = 8'h80;
  logic [7:0]  offs [4] = '{cmpctl_pkg::OFF_EDGE_EN,
    cmpctl_pkg::OFF_MINUS_SEL, cmpctl_pkg::OFF_PLUS_SEL,
    cmpctl_pkg::OFF_IRQ_EN};
  int          msk [4] = '{3, 7, 7, 1};
  int          miscompares = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          c, r, inv;
  always #5 mclk = ~mclk;
  cmpctl_core_model core (.clk_i(mclk), .en_i(cen), .plus_i(vp),
    .minus_i(vm), .tmr_run_i(run), .raw_o(raw), .tmr_o(tclk));
  cmpctl_top dut (.MCLK_I(mclk), .RST_I(rst), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .CMP_RAW_I(raw), .TMR_CLK_I(tclk),
    .OTHER_RESULT_I(other), .CMP_ENABLE_O(cen), .DEADBAND_EN_O(dben),
    .MINUS_SEL_O(msel), .PLUS_SEL_O(pselo), .MINUS_PIN_EN_O(mpin),
    .PLUS_PIN_EN_O(ppin), .PLUS_DAC_EN_O(pdac), .MINUS_REF_EN_O(mref),
    .PLUS_REF_EN_O(pref), .MINUS_GND_EN_O(mgnd), .PLUS_GND_EN_O(pgnd),
    .CMP_OUT_O(cout), .IRQ_O(irq));
  task automatic finish_test;
    if (miscompares == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic settle;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  // Request held from setup until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) miscompares++;
    @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input int d);
    apb(1'b1, a, d);
    settle();
  endtask
  task automatic rd(input logic [7:0] a, input int e, input logic x);
    apb(1'b0, a, 32'h0);
    chk("read data", e, rdat);
    chk("slave error", x, err);
  endtask
  initial begin
    r = $urandom(32'h6436_2f38);
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    for (int a = 0; a < 32; a += 4) rd(a, 0, 1'b0);
    rd(8'h20, 0, 1'b1);
    for (int i = 0; i < 6; i++) begin
      r = $urandom;
      wr(cmpctl_pkg::OFF_CTRL_A, r);
      rd(cmpctl_pkg::OFF_CTRL_A, r & 'h93 | r >> 4 << 6 & 'h40, 1'b0);
      chk("enable", r >> 7 & 1, cen);
      chk("deadband", r >> 1 & 1, dben);
      for (int k = 0; k < 4; k++) begin
        r = $urandom;
        wr(offs[k], r);
        rd(offs[k], r & msk[k], 1'b0);
      end
    end
    wr(cmpctl_pkg::OFF_CTRL_A, 'h80);
    for (c = 0; c < 8; c++) begin
      wr(cmpctl_pkg::OFF_MINUS_SEL, c);
      wr(cmpctl_pkg::OFF_PLUS_SEL, c);
      chk("selects", c << 3 | c, {msel, pselo});
      chk("minus route", c < 4 ? 1 << c : c > 5 ? 1 << (c - 2) : 0,
          {mgnd, mref, mpin});
      chk("plus route", c < 2 ? 1 << c : c > 4 ? 1 << (c - 3) : 0,
          {pgnd, pref, pdac, ppin});
    end
    wr(cmpctl_pkg::OFF_CTRL_A, 'h00);
    chk("route off", 0, {mgnd, mref, mpin, pgnd, pref, pdac, ppin});
    for (int i = 0; i < 4; i++) begin
      inv = i & 1;
      vp = i > 1 ? 8'hC0 : 8'h40;
      other = i[0];
      wr(cmpctl_pkg::OFF_CTRL_A, 'h80 | inv << 4);
      r = (vp > vm) ^ inv;
      rd(cmpctl_pkg::OFF_CTRL_A, 'h80 | inv << 4 | r << 6, 1'b0);
      rd(cmpctl_pkg::OFF_MIRROR, r | inv << 1, 1'b0);
      chk("timer output", r, cout);
    end
    wr(cmpctl_pkg::OFF_CTRL_A, 'h80);
    wr(cmpctl_pkg::OFF_IRQ_EN, 1);
    for (int e = 0; e < 4; e++) begin
      vp = 8'h40;
      wr(cmpctl_pkg::OFF_EDGE_EN, e);
      wr(cmpctl_pkg::OFF_IRQ_CLR, 1);
      vp = 8'hC0;
      settle();
      rd(cmpctl_pkg::OFF_IRQ_STAT, e >> 1, 1'b0);
      chk("irq line", e >> 1, irq);
      wr(cmpctl_pkg::OFF_IRQ_CLR, 1);
      vp = 8'h40;
      settle();
      settle();
      rd(cmpctl_pkg::OFF_IRQ_STAT, e & 1, 1'b0);
    end
    wr(cmpctl_pkg::OFF_IRQ_EN, 0);
    chk("irq masked", 0, irq);
    wr(cmpctl_pkg::OFF_CTRL_A, 'h00);
    wr(cmpctl_pkg::OFF_EDGE_EN, 2);
    wr(cmpctl_pkg::OFF_IRQ_CLR, 1);
    rd(cmpctl_pkg::OFF_IRQ_STAT, 0, 1'b0);
    wr(cmpctl_pkg::OFF_CTRL_A, 'h10);
    rd(cmpctl_pkg::OFF_IRQ_STAT, 1, 1'b0);
    wr(cmpctl_pkg::OFF_CTRL_A, 'h80);
    chk("timer output", 0, cout);
    wr(cmpctl_pkg::OFF_CTRL_A, 'h81);
    vp = 8'hC0;
    settle();
    chk("held output", 0, cout);
    run = 1'b1;
    repeat (12) @(posedge mclk);
    #1;
    chk("retimed output", 1, cout);
    finish_test();
  end
endmodule
`default_nettype wire

// ### rtl/cmpctl_pkg.sv
// Register map, field positions and encodings for the comparator control block
package cmpctl_pkg;
  localparam logic [7:0] OFF_CTRL_A    = 8'h00;
  localparam logic [7:0] OFF_EDGE_EN   = 8'h04;
  localparam logic [7:0] OFF_MINUS_SEL = 8'h08;
  localparam logic [7:0] OFF_PLUS_SEL  = 8'h0C;
  localparam logic [7:0] OFF_MIRROR    = 8'h10;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h14;
  localparam logic [7:0] OFF_IRQ_EN    = 8'h18;
  localparam logic [7:0] OFF_IRQ_CLR   = 8'h1C;
  localparam int B_ENABLE  = 7;
  localparam int B_RESULT  = 6;
  localparam int B_INVERT  = 4;
  localparam int B_DEADBND = 1;
  localparam int B_RETIME  = 0;
  localparam int B_RISE    = 1;
  localparam int B_FALL    = 0;
  localparam int B_MIR_1   = 0;
  localparam int B_MIR_2   = 1;
  localparam int B_EVT     = 0;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [2:0] MSEL_REF2 = 3'h6;
  localparam logic [2:0] MSEL_GND  = 3'h7;
  localparam logic [2:0] PSEL_DAC  = 3'h5;
  localparam logic [2:0] PSEL_REF2 = 3'h6;
  localparam logic [2:0] PSEL_GND  = 3'h7;
endpackage

// ### rtl/cmpctl_top.sv
// Comparator control and status logic with APB register slave
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module cmpctl_top (
  input  wire logic        MCLK_I,
  input  wire logic        RST_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic        CMP_RAW_I,
  input  wire logic        TMR_CLK_I,
  input  wire logic        OTHER_RESULT_I,
  output logic             CMP_ENABLE_O,
  output logic             DEADBAND_EN_O,
  output logic      [2:0]  MINUS_SEL_O,
  output logic      [2:0]  PLUS_SEL_O,
  output logic      [3:0]  MINUS_PIN_EN_O,
  output logic      [1:0]  PLUS_PIN_EN_O,
  output logic             PLUS_DAC_EN_O,
  output logic             MINUS_REF_EN_O,
  output logic             PLUS_REF_EN_O,
  output logic             MINUS_GND_EN_O,
  output logic             PLUS_GND_EN_O,
  output logic             CMP_OUT_O,
  output logic             IRQ_O
);
  logic       enable_q, invert_q, deadband_q, retime_q;
  logic       rise_en_q, fall_en_q;
  logic [2:0] msel_q, psel_q;
  logic       result_q, result_prev_q, other_q;
  logic       flag_q, irq_en_q;
  logic       tclk_prev_q, ext_q;
  logic       wr, rd, hit, edge_evt, clr_evt, tclk_fall, result_d;

  assign wr = PSEL_I & PENABLE_I & PWRITE_I;
  assign rd = PSEL_I & ~PENABLE_I & ~PWRITE_I;

  // Comparator core gated off when disabled, inputs disconnect too
  assign result_d = (enable_q & CMP_RAW_I) ^ invert_q;

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      enable_q   <= 1'b0;
      invert_q   <= 1'b0;
      deadband_q <= 1'b0;
      retime_q   <= 1'b0;
      rise_en_q  <= 1'b0;
      fall_en_q  <= 1'b0;
      msel_q     <= 3'h0;
      psel_q     <= 3'h0;
      irq_en_q   <= 1'b0;
    end else if (wr) begin
      case (PADDR_I)
        cmpctl_pkg::OFF_CTRL_A: begin
          enable_q   <= PWDATA_I[cmpctl_pkg::B_ENABLE];
          invert_q   <= PWDATA_I[cmpctl_pkg::B_INVERT];
          deadband_q <= PWDATA_I[cmpctl_pkg::B_DEADBND];
          retime_q   <= PWDATA_I[cmpctl_pkg::B_RETIME];
        end
        cmpctl_pkg::OFF_EDGE_EN: begin
          rise_en_q <= PWDATA_I[cmpctl_pkg::B_RISE];
          fall_en_q <= PWDATA_I[cmpctl_pkg::B_FALL];
        end
        cmpctl_pkg::OFF_MINUS_SEL: msel_q <= PWDATA_I[2:0];
        cmpctl_pkg::OFF_PLUS_SEL:  psel_q <= PWDATA_I[2:0];
        cmpctl_pkg::OFF_IRQ_EN:    irq_en_q <= PWDATA_I[cmpctl_pkg::B_EVT];
        default: ;
      endcase
    end
  end

  // Result sampled each cycle; previous copy drives edge detection
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      result_q      <= 1'b0;
      result_prev_q <= 1'b0;
      other_q       <= 1'b0;
    end else begin
      result_q      <= result_d;
      result_prev_q <= result_q;
      other_q       <= OTHER_RESULT_I;
    end
  end

  assign edge_evt = (rise_en_q & result_q & ~result_prev_q)
                  | (fall_en_q & ~result_q & result_prev_q);
  assign clr_evt  = wr & (PADDR_I == cmpctl_pkg::OFF_IRQ_CLR)
                  & PWDATA_I[cmpctl_pkg::B_EVT];

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      flag_q <= 1'b0;
    end else if (edge_evt) begin
      flag_q <= 1'b1;
    end else if (clr_evt) begin
      flag_q <= 1'b0;
    end
  end

  // Timer clock sampled as a plain input; its fall marks retime points
  assign tclk_fall = tclk_prev_q & ~TMR_CLK_I;

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      tclk_prev_q <= 1'b0;
      ext_q       <= 1'b0;
    end else begin
      tclk_prev_q <= TMR_CLK_I;
      if (!retime_q) begin
        ext_q <= result_d;
      end else if (tclk_fall) begin
        ext_q <= result_d;
      end
    end
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      CMP_ENABLE_O   <= 1'b0;
      DEADBAND_EN_O  <= 1'b0;
      MINUS_SEL_O    <= 3'h0;
      PLUS_SEL_O     <= 3'h0;
      MINUS_PIN_EN_O <= 4'h0;
      PLUS_PIN_EN_O  <= 2'h0;
      PLUS_DAC_EN_O  <= 1'b0;
      MINUS_REF_EN_O <= 1'b0;
      PLUS_REF_EN_O  <= 1'b0;
      MINUS_GND_EN_O <= 1'b0;
      PLUS_GND_EN_O  <= 1'b0;
      IRQ_O          <= 1'b0;
    end else begin
      CMP_ENABLE_O   <= enable_q;
      DEADBAND_EN_O  <= deadband_q;
      MINUS_SEL_O    <= msel_q;
      PLUS_SEL_O     <= psel_q;
      // Codes 100 and 101 leave the minus node open
      MINUS_PIN_EN_O <= (enable_q & ~msel_q[2]) ?
                        4'(4'h1 << msel_q[1:0]) : 4'h0;
      MINUS_REF_EN_O <= enable_q & (msel_q == cmpctl_pkg::MSEL_REF2);
      MINUS_GND_EN_O <= enable_q & (msel_q == cmpctl_pkg::MSEL_GND);
      // Codes 010..100 leave the plus node open
      PLUS_PIN_EN_O  <= (enable_q & (psel_q[2:1] == 2'h0)) ?
                        2'(2'h1 << psel_q[0]) : 2'h0;
      PLUS_DAC_EN_O  <= enable_q & (psel_q == cmpctl_pkg::PSEL_DAC);
      PLUS_REF_EN_O  <= enable_q & (psel_q == cmpctl_pkg::PSEL_REF2);
      PLUS_GND_EN_O  <= enable_q & (psel_q == cmpctl_pkg::PSEL_GND);
      IRQ_O          <= (flag_q | edge_evt) & irq_en_q;
    end
  end

  assign CMP_OUT_O = ext_q;

  // Zero-wait slave; data prepared during setup phase
  assign hit = (PADDR_I == cmpctl_pkg::OFF_CTRL_A)
             | (PADDR_I == cmpctl_pkg::OFF_EDGE_EN)
             | (PADDR_I == cmpctl_pkg::OFF_MINUS_SEL)
             | (PADDR_I == cmpctl_pkg::OFF_PLUS_SEL)
             | (PADDR_I == cmpctl_pkg::OFF_MIRROR)
             | (PADDR_I == cmpctl_pkg::OFF_IRQ_STAT)
             | (PADDR_I == cmpctl_pkg::OFF_IRQ_EN)
             | (PADDR_I == cmpctl_pkg::OFF_IRQ_CLR);

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      PRDATA_O  <= 32'h0000_0000;
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O  <= PSEL_I & ~PENABLE_I;
      PSLVERR_O <= PSEL_I & ~PENABLE_I & ~hit;
      PRDATA_O  <= 32'h0000_0000;
      if (rd) begin
        case (PADDR_I)
          cmpctl_pkg::OFF_CTRL_A: begin
            PRDATA_O[cmpctl_pkg::B_ENABLE]  <= enable_q;
            PRDATA_O[cmpctl_pkg::B_RESULT]  <= result_q;
            PRDATA_O[cmpctl_pkg::B_INVERT]  <= invert_q;
            PRDATA_O[cmpctl_pkg::B_DEADBND] <= deadband_q;
            PRDATA_O[cmpctl_pkg::B_RETIME]  <= retime_q;
          end
          cmpctl_pkg::OFF_EDGE_EN: begin
            PRDATA_O[cmpctl_pkg::B_RISE] <= rise_en_q;
            PRDATA_O[cmpctl_pkg::B_FALL] <= fall_en_q;
          end
          cmpctl_pkg::OFF_MINUS_SEL: PRDATA_O[2:0] <= msel_q;
          cmpctl_pkg::OFF_PLUS_SEL:  PRDATA_O[2:0] <= psel_q;
          cmpctl_pkg::OFF_MIRROR: begin
            PRDATA_O[cmpctl_pkg::B_MIR_1] <= result_q;
            PRDATA_O[cmpctl_pkg::B_MIR_2] <= other_q;
          end
          cmpctl_pkg::OFF_IRQ_STAT: PRDATA_O[cmpctl_pkg::B_EVT] <= flag_q;
          cmpctl_pkg::OFF_IRQ_EN:   PRDATA_O[cmpctl_pkg::B_EVT] <= irq_en_q;
          default: ;
        endcase
      end
    end
  end

  property p_reg_result;
    @(posedge MCLK_I) disable iff (RST_I)
      result_q == $past(result_d);
  endproperty
  a_reg_result: assert property (p_reg_result)
    else $error("result stale");

  sequence s_rise;
    rise_en_q && result_q && !result_prev_q;
  endsequence
  property p_rise_flag;
    @(posedge MCLK_I) disable iff (RST_I) s_rise |=> flag_q;
  endproperty
  a_rise_flag: assert property (p_rise_flag) else $error("rise lost");

  property p_fall_flag;
    @(posedge MCLK_I) disable iff (RST_I)
      (fall_en_q && !result_q && result_prev_q) |=> flag_q;
  endproperty
  a_fall_flag: assert property (p_fall_flag) else $error("fall lost");

  property p_no_spurious;
    @(posedge MCLK_I) disable iff (RST_I)
      (!flag_q && !edge_evt) |=> !flag_q;
  endproperty
  a_no_spurious: assert property (p_no_spurious)
    else $error("flag set");

  property p_sticky;
    @(posedge MCLK_I) disable iff (RST_I)
      (flag_q && !clr_evt) |=> flag_q;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped");

  property p_direct;
    @(posedge MCLK_I) disable iff (RST_I)
      !retime_q |=> CMP_OUT_O == $past(result_d);
  endproperty
  a_direct: assert property (p_direct) else $error("direct path");

  property p_retime_hold;
    @(posedge MCLK_I) disable iff (RST_I)
      (retime_q && !tclk_fall) |=> $stable(CMP_OUT_O);
  endproperty
  a_retime_hold: assert property (p_retime_hold) else $error("retime");

  property p_enable_out;
    @(posedge MCLK_I) disable iff (RST_I)
      ##1 CMP_ENABLE_O == $past(enable_q);
  endproperty
  a_enable_out: assert property (p_enable_out) else $error("enable");

  property p_minus_gnd;
    @(posedge MCLK_I) disable iff (RST_I)
      (enable_q && msel_q == cmpctl_pkg::MSEL_GND) |=>
        MINUS_GND_EN_O && MINUS_PIN_EN_O == 4'h0;
  endproperty
  a_minus_gnd: assert property (p_minus_gnd) else $error("minus gnd");

  property p_plus_dac;
    @(posedge MCLK_I) disable iff (RST_I)
      (enable_q && psel_q == cmpctl_pkg::PSEL_DAC) |=> PLUS_DAC_EN_O;
  endproperty
  a_plus_dac: assert property (p_plus_dac) else $error("plus dac");

  // Bus phases shared by the register checks
  sequence s_setup_rd;
    PSEL_I && !PENABLE_I && !PWRITE_I;
  endsequence
  sequence s_access_wr;
    PSEL_I && PENABLE_I && PWRITE_I;
  endsequence

  property p_unmapped_read;
    @(posedge MCLK_I) disable iff (RST_I)
      (s_setup_rd ##0 !hit) |=>
        PREADY_O && PSLVERR_O && PRDATA_O == 32'h0000_0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read");

  property p_ctrl_gaps;
    @(posedge MCLK_I) disable iff (RST_I)
      (s_setup_rd ##0 (PADDR_I == cmpctl_pkg::OFF_CTRL_A)) |=>
        PRDATA_O[31:8] == 24'h00_0000 && PRDATA_O[5] == 1'b0
        && PRDATA_O[3:2] == 2'h0;
  endproperty
  a_ctrl_gaps: assert property (p_ctrl_gaps) else $error("gap bits");

  property p_mirror_read;
    @(posedge MCLK_I) disable iff (RST_I)
      (s_setup_rd ##0 (PADDR_I == cmpctl_pkg::OFF_MIRROR)) |=>
        PRDATA_O == {30'h0000_0000, $past(other_q), $past(result_q)};
  endproperty
  a_mirror_read: assert property (p_mirror_read)
    else $error("mirror");

  property p_invert_write;
    @(posedge MCLK_I) disable iff (RST_I)
      (s_access_wr ##0 (PADDR_I == cmpctl_pkg::OFF_CTRL_A)) |=>
        invert_q == $past(PWDATA_I[cmpctl_pkg::B_INVERT]);
  endproperty
  a_invert_write: assert property (p_invert_write)
    else $error("invert write");

  property p_edge_write;
    @(posedge MCLK_I) disable iff (RST_I)
      (s_access_wr ##0 (PADDR_I == cmpctl_pkg::OFF_EDGE_EN)) |=>
        rise_en_q == $past(PWDATA_I[cmpctl_pkg::B_RISE])
        && fall_en_q == $past(PWDATA_I[cmpctl_pkg::B_FALL]);
  endproperty
  a_edge_write: assert property (p_edge_write)
    else $error("edge enables");

  // Disabled core reads low, so invert alone sets the result
  property p_disabled_result;
    @(posedge MCLK_I) disable iff (RST_I)
      !enable_q |-> result_d == invert_q;
  endproperty
  a_disabled_result: assert property (p_disabled_result)
    else $error("disabled result");

  property p_clear_flag;
    @(posedge MCLK_I) disable iff (RST_I)
      (clr_evt && !edge_evt) |=> !flag_q;
  endproperty
  a_clear_flag: assert property (p_clear_flag) else $error("clear");

  property p_irq_level;
    @(posedge MCLK_I) disable iff (RST_I)
      (flag_q && irq_en_q) |=> IRQ_O;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq");

  property p_retime_update;
    @(posedge MCLK_I) disable iff (RST_I)
      (retime_q && tclk_fall) |=> CMP_OUT_O == $past(result_d);
  endproperty
  a_retime_update: assert property (p_retime_update)
    else $error("retime update");

  property p_route_off;
    @(posedge MCLK_I) disable iff (RST_I)
      !enable_q |=> {MINUS_PIN_EN_O, PLUS_PIN_EN_O, PLUS_DAC_EN_O,
        MINUS_REF_EN_O, PLUS_REF_EN_O, MINUS_GND_EN_O,
        PLUS_GND_EN_O} == 11'h000;
  endproperty
  a_route_off: assert property (p_route_off) else $error("route");

  property p_minus_open;
    @(posedge MCLK_I) disable iff (RST_I)
      (enable_q && msel_q[2:1] == 2'h2) |=>
        MINUS_PIN_EN_O == 4'h0 && !MINUS_REF_EN_O && !MINUS_GND_EN_O;
  endproperty
  a_minus_open: assert property (p_minus_open)
    else $error("minus open");

  property p_plus_ref;
    @(posedge MCLK_I) disable iff (RST_I)
      (enable_q && psel_q == cmpctl_pkg::PSEL_REF2) |=>
        PLUS_REF_EN_O && PLUS_PIN_EN_O == 2'h0 && !PLUS_GND_EN_O;
  endproperty
  a_plus_ref: assert property (p_plus_ref) else $error("plus ref");

  // First clock in reset only clears; state is checked from the second
  property p_reset_clear;
    @(posedge MCLK_I)
      (RST_I ##1 RST_I) |->
        !enable_q && !flag_q && !CMP_OUT_O && !IRQ_O && !PREADY_O;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("reset state");
endmodule
`default_nettype wire
